// ==== core/irq_flags_pkg.sv ====
// constants, register map and state types for the interrupt request flag block
// Notes on behaviour
// - write bit 7 picks set or clear
// - second flag register: only bits 5..0 writable
// - host edits flags without disturbing others
// - fifo high mark rise latches bit 6
// - fifo low mark rise latches bit 5
// - self-ended command sets bit 4, host idle not
// - transmit completion sets bit 3
// - receive end sets bit 2 regardless of data
// - any listed error sets bit 1
// - frame start sets bit 0
// - bit 6 of second register: combined request
// - card detection sets second register bit 5
// - timer n underflow sets bit n
// - first enables gate first flags into request
// - enable bit 7 inverts the pin
// - first flag register resets to zero
// - pin follows request only when pin enabled
// - second enable bit 7: push-pull else open-drain
// - second enables gate card and timer flags
package irq_flags_pkg;

    localparam logic [7:0] flags_a_addr = 8'h06;
    localparam logic [7:0] flags_b_addr = 8'h07;
    localparam logic [7:0] enables_a_addr = 8'h08;
    localparam logic [7:0] enables_b_addr = 8'h09;

    localparam int polarity_bit = 7;
    localparam int invert_bit = 7;
    localparam int driver_bit = 7;
    localparam int pin_enable_bit = 6;
    localparam int combined_bit = 6;

    localparam logic [6:0] flags_a_mask = 7'h7F;
    localparam logic [6:0] flags_b_mask = 7'h3F;

    localparam logic [6:0] flags_a_reset = 7'h00;
    localparam logic [5:0] flags_b_reset = 6'h00;
    localparam logic [7:0] enables_a_reset = 8'h00;
    localparam logic [7:0] enables_b_reset = 8'h00;
    localparam logic [7:0] rdata_reset = 8'h00;

    localparam int edge_width = 7;

    // live status levels watched for rising edges
    typedef struct packed {
        logic [4:0] errors;      // write violation, overrun, framing, empty send, integrity
        logic fifo_high;
        logic fifo_low;
    } level_inputs_t;

    typedef struct packed {
        logic transmit_done;
        logic receive_end;
        logic frame_start;
        logic card_detect;
        logic [4:0] timer_underflow;
        logic command_idle;      // command field reads idle
        logic host_idle_start;   // host itself wrote the idle command
    } pulse_inputs_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [6:0] flags_a;
        logic [5:0] flags_b;
        logic combined;
        logic [7:0] enables_a;
        logic [7:0] enables_b;
        logic [7:0] rdata;
        logic idle_prev;
        logic host_idle_prev;
    } core_state_t;

    typedef struct packed {
        logic [edge_width-1:0] prev;
        logic [edge_width-1:0] rise;
    } edge_state_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_state_t;

endpackage

// ==== core/level_rise_detect.sv ====
// rising edge detector for the live status levels
`timescale 1ns/1ps
module level_rise_detect (
    input wire logic sys_clk,                                       // system clock
    input wire logic reset_n,                                       // synchronous reset
    input wire logic [irq_flags_pkg::edge_width-1:0] level_in,      // same-clock levels
    output logic [irq_flags_pkg::edge_width-1:0] rise_out           // one-cycle rise pulses
);
    irq_flags_pkg::edge_state_t state_q;
    irq_flags_pkg::edge_state_t state_d;

    always_comb begin
        state_d = state_q;
        state_d.prev = level_in;
        state_d.rise = level_in & ~state_q.prev;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // prev at zero: a level already high after reset counts as an event
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rise_out = state_q.rise;
endmodule // level_rise_detect

// ==== core/request_pin_driver.sv ====
// interrupt pin polarity, gating and driver style
`timescale 1ns/1ps
module request_pin_driver (
    input wire logic sys_clk,            // system clock
    input wire logic reset_n,            // synchronous reset
    input wire logic request,            // combined request level
    input wire logic pin_enable,         // pass request to pin
    input wire logic invert,             // inverted pin polarity
    input wire logic push_pull,          // 1 push-pull, 0 open-drain
    output logic pin_out,                // pin output value
    output logic pin_oe                  // pin output enable
);
    irq_flags_pkg::pin_state_t state_q;
    irq_flags_pkg::pin_state_t state_d;
    logic level;

    always_comb begin
        level = (request & pin_enable) ^ invert;
        state_d = state_q;
        if (push_pull) begin
            state_d.out = level;
            state_d.oe = 1'b1;
        end else begin
            // open-drain only pulls low; high comes from the board pull-up
            state_d.out = 1'b0;
            state_d.oe = ~level;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign pin_out = state_q.out;
    assign pin_oe = state_q.oe;
endmodule // request_pin_driver

// ==== core/frontend_interrupt_flags.sv ====
// latched interrupt request flags, enables and combined request of the reader frontend
`timescale 1ns/1ps
module frontend_interrupt_flags (
    input wire logic sys_clk,                               // system clock, 10 MHz
    input wire logic reset_n,                               // synchronous reset
    input wire irq_flags_pkg::reg_req_t reg_req,            // register access from host port
    input wire irq_flags_pkg::level_inputs_t level_in,      // live fifo and error levels
    input wire irq_flags_pkg::pulse_inputs_t pulse_in,      // event pulses
    output logic [7:0] reg_rdata,                           // read data, one cycle after rd
    output logic combined_request,                          // combined request level
    output logic irq_pin_out,                               // interrupt pin value
    output logic irq_pin_oe                                 // interrupt pin drive enable
);
    irq_flags_pkg::core_state_t state_q;
    irq_flags_pkg::core_state_t state_d;
    logic [irq_flags_pkg::edge_width-1:0] rise;
    logic [6:0] hw_a;
    logic [5:0] hw_b;
    logic command_done_event;

    // polarity write: ones in data pick the bits, bit 7 decides set or clear
    function automatic logic [6:0] apply_write(
        input logic [6:0] old,
        input logic [7:0] data,
        input logic [6:0] mask
    );
        logic [6:0] sel;
        sel = data[6:0] & mask;
        if (data[irq_flags_pkg::polarity_bit]) begin
            apply_write = old | sel;
        end else begin
            apply_write = old & ~sel;
        end
    endfunction

    level_rise_detect u_rise (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .level_in(level_in),
        .rise_out(rise)
    );

    // one cycle late against pulses; keeps the edge logic out of this file
    always_comb begin
        command_done_event = pulse_in.command_idle & ~state_q.idle_prev
            & ~pulse_in.host_idle_start & ~state_q.host_idle_prev;
        hw_a = '0;
        hw_a[6] = rise[1];
        hw_a[5] = rise[0];
        hw_a[4] = command_done_event;
        hw_a[3] = pulse_in.transmit_done;
        hw_a[2] = pulse_in.receive_end;
        hw_a[1] = |rise[6:2];
        hw_a[0] = pulse_in.frame_start;
        hw_b = {pulse_in.card_detect, pulse_in.timer_underflow};
    end

    always_comb begin
        logic [6:0] wr_b;
        wr_b = '0;
        state_d = state_q;
        state_d.idle_prev = pulse_in.command_idle;
        state_d.host_idle_prev = pulse_in.host_idle_start;
        if (reg_req.wr) begin
            if (reg_req.addr == irq_flags_pkg::flags_a_addr) begin
                state_d.flags_a = apply_write(state_q.flags_a, reg_req.wdata,
                    irq_flags_pkg::flags_a_mask);
            end else if (reg_req.addr == irq_flags_pkg::flags_b_addr) begin
                wr_b = apply_write({1'b0, state_q.flags_b}, reg_req.wdata,
                    irq_flags_pkg::flags_b_mask);
                state_d.flags_b = wr_b[5:0];
            end else if (reg_req.addr == irq_flags_pkg::enables_a_addr) begin
                state_d.enables_a = reg_req.wdata;
            end else if (reg_req.addr == irq_flags_pkg::enables_b_addr) begin
                state_d.enables_b = reg_req.wdata;
            end
        end
        // events or'ed last so a same-cycle clear cannot drop them
        state_d.flags_a = state_d.flags_a | hw_a;
        state_d.flags_b = state_d.flags_b | hw_b;
        state_d.combined = |(state_d.flags_a & state_d.enables_a[6:0])
            | |(state_d.flags_b & state_d.enables_b[5:0]);
        state_d.rdata = irq_flags_pkg::rdata_reset;
        if (reg_req.rd) begin
            if (reg_req.addr == irq_flags_pkg::flags_a_addr) begin
                state_d.rdata = {1'b0, state_q.flags_a};
            end else if (reg_req.addr == irq_flags_pkg::flags_b_addr) begin
                state_d.rdata = {1'b0, state_q.combined, state_q.flags_b};
            end else if (reg_req.addr == irq_flags_pkg::enables_a_addr) begin
                state_d.rdata = state_q.enables_a;
            end else if (reg_req.addr == irq_flags_pkg::enables_b_addr) begin
                state_d.rdata = state_q.enables_b;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q.flags_a <= irq_flags_pkg::flags_a_reset;
            state_q.flags_b <= irq_flags_pkg::flags_b_reset;
            state_q.combined <= 1'b0;
            state_q.enables_a <= irq_flags_pkg::enables_a_reset;
            state_q.enables_b <= irq_flags_pkg::enables_b_reset;
            state_q.rdata <= irq_flags_pkg::rdata_reset;
            state_q.idle_prev <= 1'b1;
            state_q.host_idle_prev <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    request_pin_driver u_pin (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .request(state_q.combined),
        .pin_enable(state_q.enables_b[irq_flags_pkg::pin_enable_bit]),
        .invert(state_q.enables_a[irq_flags_pkg::invert_bit]),
        .push_pull(state_q.enables_b[irq_flags_pkg::driver_bit]),
        .pin_out(irq_pin_out),
        .pin_oe(irq_pin_oe)
    );

    assign reg_rdata = state_q.rdata;
    assign combined_request = state_q.combined;
endmodule // frontend_interrupt_flags

// ==== test/irq_flags_properties.sv ====
// port checker for the interrupt flag block
`timescale 1ns/1ps
module irq_flags_properties (
    input wire logic sys_clk, // clock
    input wire logic reset_n, // reset
    input wire irq_flags_pkg::reg_req_t reg_req, // host access
    input wire irq_flags_pkg::level_inputs_t level_in, // levels
    input wire irq_flags_pkg::pulse_inputs_t pulse_in, // pulses
    input wire logic [7:0] reg_rdata, // read data
    input wire logic combined_request, // request
    input wire logic irq_pin_out, // pin value
    input wire logic irq_pin_oe // pin enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // no write between event and read, so the flag must still be there
    sequence rd_at(logic [7:0] a);
        !reg_req.wr ##1 reg_req.rd && reg_req.addr == a;
    endsequence
    a_set_bit_zero: assert property (reg_req.rd && reg_req.addr == 8'h06 |=> !reg_rdata[7])
        else $error("set bit read back");
    a_tx_flag_set: assert property (pulse_in.transmit_done ##1 rd_at(8'h06) |=> reg_rdata[3])
        else $error("tx flag missing");
    a_rx_flag_set: assert property (pulse_in.receive_end ##1 rd_at(8'h06) |=> reg_rdata[2])
        else $error("rx flag missing");
    a_sof_flag_set: assert property (pulse_in.frame_start ##1 rd_at(8'h06) |=> reg_rdata[0])
        else $error("sof flag missing");
    a_card_flag_set: assert property (pulse_in.card_detect ##1 rd_at(8'h07) |=> reg_rdata[5])
        else $error("card flag missing");
    a_timer_flag_set: assert property ((pulse_in.timer_underflow != 5'h00) ##1 rd_at(8'h07) |=>
        (reg_rdata[4:0] & $past(pulse_in.timer_underflow, 3)) == $past(pulse_in.timer_underflow, 3))
        else $error("timer flag missing");
    a_combined_read: assert property (reg_req.rd && reg_req.addr == 8'h07 |=>
        reg_rdata[7:6] == {1'b0, $past(combined_request)}) else $error("combined bit wrong");
    a_od_no_high: assert property (irq_pin_out |-> irq_pin_oe)
        else $error("pin high undriven");
    a_request_drops: assert property ((reg_req.wr && reg_req.addr == 8'h08 && reg_req.wdata == 8'h00) ##2
        (reg_req.wr && reg_req.addr == 8'h09 && reg_req.wdata == 8'h00) ##1 !reg_req.wr [*2]
        |=> !combined_request) else $error("request stuck");
    c_request: cover property (combined_request);
    c_push_high: cover property (irq_pin_out && irq_pin_oe);
    c_set_write: cover property (reg_req.wr && reg_req.wdata[7]);
endmodule // irq_flags_properties

bind frontend_interrupt_flags irq_flags_properties props_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_req(reg_req), .level_in(level_in), .pulse_in(pulse_in), .reg_rdata(reg_rdata),
    .combined_request(combined_request), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));

// ==== test/host_model.sv ====
// host side register access model
`timescale 1ns/1ps
module host_model (
    input wire logic sys_clk, // clock
    input wire logic [7:0] reg_rdata, // read data
    output irq_flags_pkg::reg_req_t reg_req // access
);
    initial reg_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= {a, d, 2'b10};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
        // released data must not look valid
        reg_req.wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= {a, 8'h00, 2'b01};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        // read data stands one cycle only: take it mid-cycle
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
endmodule // host_model

// ==== test/frontend_interrupt_flags_tb.sv ====
// self-checking bench for the interrupt flag block
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %0t %h %h", $time, a, e); end end
module frontend_interrupt_flags_tb;
    logic sys_clk = 0;
    logic reset_n = 0;
    irq_flags_pkg::reg_req_t reg_req;
    irq_flags_pkg::level_inputs_t level_in = '0;
    irq_flags_pkg::pulse_inputs_t pulse_in = '0;
    logic [7:0] reg_rdata;
    logic combined_request, irq_pin_out, irq_pin_oe;
    int fail_count = 0;
    int check_count = 0;
    always #50 sys_clk = ~sys_clk;
    frontend_interrupt_flags dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req),
        .level_in(level_in), .pulse_in(pulse_in), .reg_rdata(reg_rdata),
        .combined_request(combined_request), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
    host_model hm (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        hm.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic pulse(input logic [10:0] v);
        @(posedge sys_clk);
        pulse_in <= v;
        @(posedge sys_clk);
        pulse_in <= '0;
    endtask
    task automatic lvl(input logic [6:0] v);
        @(posedge sys_clk);
        level_in <= v;
        repeat (4) @(posedge sys_clk);
        level_in <= '0;
    endtask
    task automatic pin(input logic [7:0] ea, input logic [7:0] eb, input logic [1:0] e);
        hm.wr(8'h08, ea);
        hm.wr(8'h09, eb);
        repeat (3) @(posedge sys_clk);
        `CHK({irq_pin_out, irq_pin_oe}, e)
    endtask
    task automatic t_reset;
        for (int a = 6; a < 10; a++) rc(a[7:0], 8'h00);
        hm.wr(8'h0A, 8'hFF);
        rc(8'h0A, 8'h00);
    endtask
    task automatic t_setclr;
        hm.wr(8'h06, 8'hFF);
        rc(8'h06, 8'h7F);
        hm.wr(8'h06, 8'h05);
        rc(8'h06, 8'h7A);
        hm.wr(8'h06, 8'h7F);
        rc(8'h06, 8'h00);
        hm.wr(8'h07, 8'hFF);
        rc(8'h07, 8'h3F);
        hm.wr(8'h07, 8'h7F);
        hm.wr(8'h07, 8'hC0);
        rc(8'h07, 8'h00);
    endtask
    task automatic t_events;
        pulse(11'h7FC);
        rc(8'h06, 8'h0D);
        pulse(11'h7FC);
        rc(8'h07, 8'h3F);
        hm.wr(8'h06, 8'h7F);
        hm.wr(8'h07, 8'h3F);
        lvl(7'h03);
        rc(8'h06, 8'h60);
        for (int k = 2; k < 7; k++) begin
            hm.wr(8'h06, 8'h7F);
            lvl(7'h01 << k);
            rc(8'h06, 8'h02);
        end
        hm.wr(8'h06, 8'h7F);
    endtask
    task automatic t_cmd;
        pulse(11'h002);
        rc(8'h06, 8'h10);
        hm.wr(8'h06, 8'h10);
        pulse(11'h003);
        rc(8'h06, 8'h00);
    endtask
    task automatic t_race;
        fork
            hm.wr(8'h06, 8'h08);
            pulse(11'h400);
        join
        rc(8'h06, 8'h08);
    endtask
    task automatic t_pin;
        pin(8'h08, 8'h00, 2'b01);
        `CHK(combined_request, 1'b1)
        rc(8'h07, 8'h40);
        pin(8'h08, 8'hC0, 2'b11);
        pin(8'h88, 8'hC0, 2'b01);
        pin(8'h88, 8'h40, 2'b01);
        pin(8'h08, 8'h40, 2'b00);
        hm.wr(8'h06, 8'h08);
        repeat (3) @(posedge sys_clk);
        `CHK({combined_request, irq_pin_oe}, 2'b01)
        pulse(11'h004);
        pin(8'h00, 8'h41, 2'b00);
        pin(8'h00, 8'h40, 2'b01);
        hm.wr(8'h08, 8'h00);
        hm.wr(8'h09, 8'h00);
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset;
        t_setclr;
        t_events;
        t_cmd;
        t_race;
        t_pin;
        finish_test;
    end
    // a hang counts as a mismatch
    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        finish_test;
    end
endmodule // frontend_interrupt_flags_tb
